// *** hdl/srvio_pkg.sv ***
// Constants for the servo I/O function mapper
package srvio_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_IN_FUNC = 8'h00;
  localparam logic [7:0] OFS_OUT_CFG = 8'h04;
  localparam logic [7:0] OFS_STAT_CFG = 8'h08;
  localparam logic [7:0] OFS_REL_WAIT = 8'h0C;
  localparam logic [7:0] OFS_APP_WAIT = 8'h10;
  localparam logic [7:0] OFS_GP_OUT = 8'h14;
  localparam logic [7:0] OFS_STATE = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
  // ==========================================================
  // Field positions, one nibble per digit
  localparam int DIG_GAIN = 0;
  localparam int DIG_GEAR = 4;
  localparam int DIG_LOOP = 8;
  localparam int DIG_HOLD = 12;
  localparam int DIG_FAULT = 0;
  localparam int DIG_BRAKE = 4;
  localparam int DIG_TORQ = 0;
  localparam int DIG_ERRSPD = 4;
  localparam int DIG_ENAB = 8;
  localparam int DIG_SETTLE = 12;
  localparam int EV_FAULT = 0;
  localparam int EV_REL_DONE = 1;
  localparam int EV_APP_DONE = 2;
  localparam int NUM_EV = 3;
  // ==========================================================
  // Reset values
  localparam logic [15:0] RST_IN_FUNC = 16'h3333;
  localparam logic [7:0] RST_OUT_CFG = 8'h33;
  localparam logic [15:0] RST_STAT_CFG = 16'h3333;
  localparam logic [15:0] RST_WAIT_MS = 16'h00C8;
  localparam logic [15:0] MAX_WAIT_MS = 16'h7D00;
  localparam logic [5:0] RST_GP_OUT = 6'h3F;
  // ==========================================================
  // Timing
  localparam int CLK_FREQ_MHZ = 100;
  localparam int TICK_TIME_US = 1000;
  localparam int TICK_CYCLES = TICK_TIME_US * CLK_FREQ_MHZ;
  // ==========================================================
  // Drive power sequence
  typedef enum logic [1:0] {
    ST_OFF,
    ST_RELEASE,
    ST_RUN,
    ST_APPLY
  } srvio_state_e;
endpackage : srvio_pkg

// *** hdl/srvio_timer_if.sv ***
// Link between the sequencer and one brake wait timer
`timescale 1ns/1ps
interface srvio_timer_if;
  logic ce;
  logic tick;
  logic load;
  logic [15:0] value;
  logic busy;
  logic done;
  modport ctl (output ce, tick, load, value, input busy, done);
  modport tmr (input ce, tick, load, value, output busy, done);
endinterface : srvio_timer_if

// *** hdl/srvio_wait_timer.sv ***
// Millisecond countdown for a brake wait
`timescale 1ns/1ps
module srvio_wait_timer (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, low
  srvio_timer_if.tmr tif // Control link
);
  logic [15:0] cnt_reg;
  logic busy_reg;
  logic done_reg;

  assign tif.busy = busy_reg;
  assign tif.done = done_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 16'h0000;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else if (tif.ce) begin
      if (tif.load) begin
        cnt_reg <= tif.value;
        busy_reg <= (tif.value != 16'h0000);
        done_reg <= (tif.value == 16'h0000);
      end else if (tif.tick && busy_reg) begin
        cnt_reg <= cnt_reg - 16'h0001;
        busy_reg <= (cnt_reg != 16'h0001);
        done_reg <= (cnt_reg == 16'h0001);
      end else begin
        done_reg <= 1'b0;
      end
    end
  end

  a_zero_expire: assert property (@(posedge pclk) disable iff (!presetn)
    tif.ce && tif.load && tif.value == 16'h0000 |=> done_reg)
    else $error("zero wait did not expire at once");
  a_count_busy: assert property (@(posedge pclk) disable iff (!presetn)
    tif.ce && tif.load && tif.value != 16'h0000 |=> busy_reg && !done_reg)
    else $error("nonzero wait did not start counting");
endmodule : srvio_wait_timer

// *** hdl/srvio_mapper.sv ***
// Servo I/O function mapper with brake sequencing and APB registers
// What this block does
// - Gain switch input selects alternate/main gain
// - Gear input selects gear source A/B
// - Loop input selects first/second loop type
// - Count hold input inhibits pulse counting
// - Input setting: four digits, default 3333
// - Fault output polarity or general use
// - Brake output follows enable, or general
// - Status setting: four hex digits, 3333
// - Torque flag closes or opens on reach
// - Second output: position window or speed
// - Enabled flag closes or opens when enabled
// - Settled flag: in position, or running
// - Brake waits only with brake config 1/2
// - Release wait counts down, blocks moves
// - Apply wait delays power stage off
// - Brake engages at once on disable
`timescale 1ns/1ps
module srvio_mapper
  import srvio_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  input wire logic pclk, // Clock, 100 MHz
  input wire logic presetn, // Async reset, low
  input wire logic ce, // Clock enable
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic gain_switch_input, // High when closed
  input wire logic gear_ratio_input, // High when closed
  input wire logic loop_type_input, // High when closed
  input wire logic count_hold_input, // High when closed
  input wire logic enable_req, // Drive enable command
  input wire logic drive_fault, // Drive fault present
  input wire logic torque_reached, // Torque at target
  input wire logic pos_in_window, // Position error in window
  input wire logic speed_reached, // Speed at target
  input wire logic motion_done, // Move done, in position
  input wire logic motor_running, // Motor turning
  output logic gain_set_alt, // Alternate gain set chosen
  output logic gear_ratio_b, // Gear source B chosen
  output logic loop_type_second, // Second loop type chosen
  output logic count_inhibit, // Pulse counting held
  output logic move_permit, // Moves allowed
  output logic power_stage_on, // Motor current on
  output logic fault_output, // Pin, low is closed
  output logic brake_output, // Pin, low is closed
  output logic torque_flag_output, // Pin, low is closed
  output logic error_or_speed_output, // Pin, low is closed
  output logic enabled_flag_output, // Pin, low is closed
  output logic settled_flag_output, // Pin, low is closed
  output logic irq // Level interrupt
);
  localparam int PW = $clog2(TICK_CYCLES_P + 1);

  if (TICK_CYCLES_P < 1) begin : g_bad_tick
    $error("TICK_CYCLES_P must be at least 1");
  end
  // ==========================================================
  // Decode helpers
  function automatic logic f_sel(input logic [3:0] code, input logic sw);
    f_sel = (code == 4'h1) ? sw : (code == 4'h2) ? ~sw : 1'b0;
  endfunction : f_sel

  // Closed (low) on close code, open (high) on open code, else general
  function automatic logic f_out(input logic [3:0] code, input logic [3:0] c_close,
    input logic [3:0] c_open, input logic cond, input logic gp);
    f_out = (code == c_close) ? ~cond : (code == c_open) ? cond : gp;
  endfunction : f_out

  // ==========================================================
  // Registers
  logic [15:0] in_func_reg;
  logic [7:0] out_cfg_reg;
  logic [15:0] stat_cfg_reg;
  logic [15:0] rel_wait_reg;
  logic [15:0] app_wait_reg;
  logic [5:0] gp_out_reg;
  logic [NUM_EV-1:0] irq_stat_reg;
  logic [NUM_EV-1:0] irq_mask_reg;
  logic [31:0] prdata_reg;
  srvio_state_e state_reg;
  srvio_state_e state_next;
  logic [PW-1:0] presc_reg;
  logic fault_d_reg;

  logic [3:0] gain_field, gear_field, loop_field, hold_field;
  logic [3:0] fault_cfg, brake_cfg, torq_dig, errspd_dig, enab_dig, settle_dig;
  logic brake_used, drive_enabled, tick, wr_en, addr_ok, rel_load, app_load;
  logic [31:0] rd_mux;
  logic [15:0] wait_wr;
  logic [NUM_EV-1:0] ev;

  srvio_timer_if rel_if ();
  srvio_timer_if app_if ();

  assign gain_field = in_func_reg[DIG_GAIN +: 4];
  assign gear_field = in_func_reg[DIG_GEAR +: 4];
  assign loop_field = in_func_reg[DIG_LOOP +: 4];
  assign hold_field = in_func_reg[DIG_HOLD +: 4];
  assign fault_cfg = out_cfg_reg[DIG_FAULT +: 4];
  assign brake_cfg = out_cfg_reg[DIG_BRAKE +: 4];
  assign torq_dig = stat_cfg_reg[DIG_TORQ +: 4];
  assign errspd_dig = stat_cfg_reg[DIG_ERRSPD +: 4];
  assign enab_dig = stat_cfg_reg[DIG_ENAB +: 4];
  assign settle_dig = stat_cfg_reg[DIG_SETTLE +: 4];
  assign brake_used = (brake_cfg == 4'h1) || (brake_cfg == 4'h2);
  assign drive_enabled = (state_reg == ST_RELEASE) || (state_reg == ST_RUN);

  // ==========================================================
  // APB slave: ready follows ce, data latched in setup phase
  assign pready = ce;
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= OFS_IRQ_MASK);
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en = ce && psel && penable && pwrite && addr_ok;
  assign prdata = prdata_reg;
  assign wait_wr = (pwdata[15:0] > MAX_WAIT_MS) ? MAX_WAIT_MS : pwdata[15:0];

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFS_IN_FUNC: rd_mux[15:0] = in_func_reg;
      OFS_OUT_CFG: rd_mux[7:0] = out_cfg_reg;
      OFS_STAT_CFG: rd_mux[15:0] = stat_cfg_reg;
      OFS_REL_WAIT: rd_mux[15:0] = rel_wait_reg;
      OFS_APP_WAIT: rd_mux[15:0] = app_wait_reg;
      OFS_GP_OUT: rd_mux[5:0] = gp_out_reg;
      OFS_STATE: rd_mux[15:0] = {gain_switch_input, gear_ratio_input, loop_type_input,
        count_hold_input, gain_set_alt, gear_ratio_b, loop_type_second, count_inhibit,
        move_permit, power_stage_on, rel_if.busy, app_if.busy, 2'(state_reg), 2'b00};
      OFS_IRQ_STAT: rd_mux[NUM_EV-1:0] = irq_stat_reg;
      OFS_IRQ_MASK: rd_mux[NUM_EV-1:0] = irq_mask_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (ce && psel && !penable) begin
      prdata_reg <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_func_reg <= RST_IN_FUNC;
      out_cfg_reg <= RST_OUT_CFG;
      stat_cfg_reg <= RST_STAT_CFG;
      rel_wait_reg <= RST_WAIT_MS;
      app_wait_reg <= RST_WAIT_MS;
      gp_out_reg <= RST_GP_OUT;
      irq_mask_reg <= '0;
    end else if (wr_en) begin
      case (paddr)
        OFS_IN_FUNC: in_func_reg <= pwdata[15:0];
        OFS_OUT_CFG: out_cfg_reg <= pwdata[7:0];
        OFS_STAT_CFG: stat_cfg_reg <= pwdata[15:0];
        OFS_REL_WAIT: rel_wait_reg <= wait_wr;
        OFS_APP_WAIT: app_wait_reg <= wait_wr;
        OFS_GP_OUT: gp_out_reg <= pwdata[5:0];
        OFS_IRQ_MASK: irq_mask_reg <= pwdata[NUM_EV-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Interrupts: set wins over write-one-to-clear
  assign ev[EV_FAULT] = drive_fault && !fault_d_reg;
  assign ev[EV_REL_DONE] = (state_reg == ST_RELEASE) && rel_if.done;
  assign ev[EV_APP_DONE] = (state_reg == ST_APPLY) && app_if.done;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_d_reg <= 1'b0;
      irq_stat_reg <= '0;
    end else if (ce) begin
      fault_d_reg <= drive_fault;
      if (wr_en && paddr == OFS_IRQ_STAT) begin
        irq_stat_reg <= (irq_stat_reg & ~pwdata[NUM_EV-1:0]) | ev;
      end else begin
        irq_stat_reg <= irq_stat_reg | ev;
      end
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ==========================================================
  // Millisecond tick, restarted on each timer load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_reg <= '0;
    end else if (ce) begin
      if (rel_load || app_load || tick) begin
        presc_reg <= '0;
      end else begin
        presc_reg <= presc_reg + PW'(1);
      end
    end
  end

  assign tick = (presc_reg == PW'(TICK_CYCLES_P - 1));

  // ==========================================================
  // Brake and power sequence
  always_comb begin
    state_next = state_reg;
    rel_load = 1'b0;
    app_load = 1'b0;
    case (state_reg)
      ST_OFF: begin
        if (enable_req) begin
          rel_load = brake_used;
          state_next = brake_used ? ST_RELEASE : ST_RUN;
        end
      end
      ST_RELEASE: begin
        if (!enable_req) begin
          app_load = 1'b1;
          state_next = ST_APPLY;
        end else if (rel_if.done) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!enable_req) begin
          app_load = brake_used;
          state_next = brake_used ? ST_APPLY : ST_OFF;
        end
      end
      ST_APPLY: begin
        if (app_if.done) begin
          state_next = ST_OFF;
        end
      end
      default: state_next = ST_OFF;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_OFF;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  assign rel_if.ce = ce;
  assign rel_if.tick = tick;
  assign rel_if.load = rel_load;
  assign rel_if.value = rel_wait_reg;
  assign app_if.ce = ce;
  assign app_if.tick = tick;
  assign app_if.load = app_load;
  assign app_if.value = app_wait_reg;

  srvio_wait_timer u_rel_timer (
    .pclk(pclk),
    .presetn(presetn),
    .tif(rel_if.tmr)
  );

  srvio_wait_timer u_app_timer (
    .pclk(pclk),
    .presetn(presetn),
    .tif(app_if.tmr)
  );

  // ==========================================================
  // Input function selections
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_set_alt <= 1'b0;
      gear_ratio_b <= 1'b0;
      loop_type_second <= 1'b0;
      count_inhibit <= 1'b0;
    end else if (ce) begin
      gain_set_alt <= f_sel(gain_field, ~gain_switch_input);
      gear_ratio_b <= f_sel(gear_field, gear_ratio_input);
      loop_type_second <= f_sel(loop_field, loop_type_input);
      count_inhibit <= f_sel(hold_field, count_hold_input);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      move_permit <= 1'b0;
      power_stage_on <= 1'b0;
    end else if (ce) begin
      move_permit <= (state_next == ST_RUN);
      power_stage_on <= (state_next != ST_OFF);
    end
  end

  // ==========================================================
  // Output pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_output <= RST_GP_OUT[0];
      brake_output <= RST_GP_OUT[1];
      torque_flag_output <= RST_GP_OUT[2];
      error_or_speed_output <= RST_GP_OUT[3];
      enabled_flag_output <= RST_GP_OUT[4];
      settled_flag_output <= RST_GP_OUT[5];
    end else if (ce) begin
      fault_output <= f_out(fault_cfg, 4'h1, 4'h2, drive_fault, gp_out_reg[0]);
      brake_output <= f_out(brake_cfg, 4'h1, 4'h2, drive_enabled, gp_out_reg[1]);
      torque_flag_output <= f_out(torq_dig, 4'h8, 4'h9, torque_reached, gp_out_reg[2]);
      error_or_speed_output <= f_out(errspd_dig, 4'h6, 4'h7, pos_in_window,
        f_out(errspd_dig, 4'hA, 4'hB, speed_reached, gp_out_reg[3]));
      enabled_flag_output <= f_out(enab_dig, 4'h1, 4'h2, drive_enabled, gp_out_reg[4]);
      settled_flag_output <= f_out(settle_dig, 4'h4, 4'h5, motion_done,
        f_out(settle_dig, 4'hC, 4'hC, motor_running, gp_out_reg[5]));
    end
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_gain_alt_sel: assert property (ce && gain_field == 4'h1 |=>
    gain_set_alt == !$past(gain_switch_input))
    else $error("gain set choice wrong for code 1");
  a_gear_src_sel: assert property (ce && gear_field == 4'h2 |=>
    gear_ratio_b == !$past(gear_ratio_input))
    else $error("gear source choice wrong for code 2");
  a_loop_gp_main: assert property (ce && loop_field == 4'h3 |=> !loop_type_second)
    else $error("loop type moved while input is general");
  a_hold_inhibit: assert property (ce && hold_field == 4'h1 |=>
    count_inhibit == $past(count_hold_input))
    else $error("count hold wrong for code 1");
  a_fault_pin: assert property (ce && fault_cfg == 4'h1 && drive_fault |=> !fault_output)
    else $error("fault output not closed on fault");
  a_brake_pin: assert property (ce && brake_cfg == 4'h2 |=>
    brake_output == $past(drive_enabled))
    else $error("brake output polarity wrong");
  a_torque_pin: assert property (ce && torq_dig == 4'h9 |=>
    torque_flag_output == $past(torque_reached))
    else $error("torque flag polarity wrong");
  a_enabled_pin: assert property (ce && enab_dig == 4'h1 |=>
    enabled_flag_output == !$past(drive_enabled))
    else $error("enabled flag polarity wrong");
  a_move_hold: assert property (state_reg == ST_RELEASE |-> !move_permit)
    else $error("move allowed during release wait");
  a_apply_power: assert property (ce && state_reg == ST_RUN && !enable_req && brake_used
    |=> state_reg == ST_APPLY && power_stage_on && !drive_enabled)
    else $error("power cut or brake late at disable");
  a_no_brake_skip: assert property (ce && state_reg == ST_OFF && enable_req && !brake_used
    |=> state_reg == ST_RUN)
    else $error("wait applied without brake function");

  c_release_done: cover property (state_reg == ST_RELEASE ##1 state_reg == ST_RUN);
  c_apply_done: cover property (state_reg == ST_APPLY ##1 state_reg == ST_OFF);
  c_irq_raise: cover property (!irq ##1 irq);
endmodule : srvio_mapper

// *** bench/srvio_field.sv ***
// Far side model: switches, host enable, drive status levels, brake relay
`timescale 1ns/1ps
module srvio_field (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, low
  input wire logic [3:0] sw_cmd, // Closures wanted
  input wire logic [6:0] cond_cmd, // Levels wanted
  input wire logic brake_output, // Relay pin, low closed
  output logic [3:0] sw, // Switches, high closed
  output logic [6:0] cond, // Enable, fault, torque, window, speed, done, run
  output logic brake_coil // Relay energized
);
  // ==========================================================
  // Levels change only just after a clock edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw <= 4'h0;
      cond <= 7'h00;
    end else begin
      sw <= sw_cmd;
      cond <= cond_cmd;
    end
  end
  assign brake_coil = ~brake_output;
endmodule : srvio_field

// *** bench/servo_io_function_mapper_bench.sv ***
// Self-checking bench for the servo I/O function mapper
`timescale 1ns/1ps
module servo_io_function_mapper_bench;
  import srvio_pkg::*;
  localparam int TK = 5;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq, coil;
  logic alt, gb, ls, inh, mp, pso;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] sw_cmd, sw;
  logic [6:0] cond_cmd, cond;
  logic [5:0] pin;
  int err_total, checked;
  srvio_mapper #(.TICK_CYCLES_P(TK)) i_srvio_mapper (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gain_switch_input(sw[0]), .gear_ratio_input(sw[1]), .loop_type_input(sw[2]),
    .count_hold_input(sw[3]), .enable_req(cond[0]), .drive_fault(cond[1]),
    .torque_reached(cond[2]), .pos_in_window(cond[3]), .speed_reached(cond[4]),
    .motion_done(cond[5]), .motor_running(cond[6]), .gain_set_alt(alt),
    .gear_ratio_b(gb), .loop_type_second(ls), .count_inhibit(inh), .move_permit(mp),
    .power_stage_on(pso), .fault_output(pin[0]), .brake_output(pin[1]),
    .torque_flag_output(pin[2]), .error_or_speed_output(pin[3]),
    .enabled_flag_output(pin[4]), .settled_flag_output(pin[5]), .irq(irq));
  srvio_field i_srvio_field (.pclk(pclk), .presetn(presetn), .sw_cmd(sw_cmd),
    .cond_cmd(cond_cmd), .brake_output(pin[1]), .sw(sw), .cond(cond), .brake_coil(coil));
  // ==========================================================
  // Shared tasks
  task automatic end_of_test;
    $display("Mismatches %0d of %0d checks", err_total, checked);
    if (err_total == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = pslverr === 1'b1 ? 32'hFFFF_FFFF : prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 50) begin
      err_total++;
      $display("CHECK FAILED %0t bus hang", $time);
      end_of_test();
    end
  endtask : apb
  task automatic wait_for(ref logic s, input logic v, input int lim, output int n);
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (s !== v) begin
      err_total++;
      $display("CHECK FAILED %0t wait expired", $time);
      end_of_test();
    end
  endtask : wait_for
  function automatic logic pick(input int code, input logic s);
    return code == 1 ? ~s : (code == 2 ? s : 1'b0);
  endfunction : pick
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    chk(pin, 6'h3F, "pins at reset");
    apb(1'b0, OFS_IN_FUNC, 32'h0);
    chk(rd, 32'h3333, "input setting");
    apb(1'b0, OFS_STAT_CFG, 32'h0);
    chk(rd, 32'h3333, "status setting");
    apb(1'b0, OFS_REL_WAIT, 32'h0);
    chk(rd, 32'hC8, "release wait");
    apb(1'b0, OFS_APP_WAIT, 32'h0);
    chk(rd, 32'hC8, "apply wait");
    apb(1'b0, 8'h24, 32'h0);
    chk(rd, 32'hFFFF_FFFF, "unmapped error");
  endtask : t_reset
  task automatic t_inputs;
    int g, d, m, h;
    logic [3:0] s;
    for (int c = 1; c <= 3; c++) begin
      g = c;
      d = c % 3 + 1;
      m = (c + 1) % 3 + 1;
      h = d % 3 + 1;
      apb(1'b1, OFS_IN_FUNC, {16'h0, 4'(h), 4'(m), 4'(d), 4'(g)});
      for (int k = 0; k < 3; k++) begin
        s = k == 0 ? 4'h0 : (k == 1 ? 4'hF : 4'h5);
        sw_cmd <= s;
        repeat (3) @(posedge pclk);
        chk(alt, pick(g, s[0]), "gain select");
        chk(gb, pick(d, ~s[1]), "gear select");
        chk(ls, pick(m, ~s[2]), "loop select");
        chk(inh, pick(h, ~s[3]), "count hold");
      end
    end
  endtask : t_inputs
  task automatic t_hold;
    apb(1'b1, OFS_IN_FUNC, 32'h3331);
    sw_cmd <= 4'h0;
    repeat (3) @(posedge pclk);
    chk(alt, 1'b1, "gain alt when open");
    ce <= 1'b0;
    sw_cmd <= 4'h1;
    repeat (4) @(posedge pclk);
    chk({alt, pready}, 2'b10, "frozen while ce low");
    ce <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(alt, 1'b0, "gain main when closed");
  endtask : t_hold
  task automatic t_fault;
    apb(1'b1, OFS_GP_OUT, 32'h3E);
    for (int c = 1; c <= 3; c++) begin
      apb(1'b1, OFS_OUT_CFG, 32'h30 | c);
      for (int f = 1; f >= 0; f--) begin
        cond_cmd <= 7'(f << 1);
        repeat (3) @(posedge pclk);
        chk(pin[0], c == 3 ? 1'b0 : (c == 1 ? f == 0 : f == 1), "fault pin");
      end
    end
    chk(irq, 1'b0, "irq masked");
    apb(1'b1, OFS_IRQ_MASK, 32'h1);
    chk(irq, 1'b1, "irq raised");
    apb(1'b1, OFS_IRQ_STAT, 32'h1);
    chk(irq, 1'b0, "irq cleared");
  endtask : t_fault
  task automatic t_status;
    logic [27:0] tbl [9] = '{28'h3338_221, 28'h3339_220, 28'h3363_331, 28'h3373_330,
      28'h33A3_431, 28'h33B3_430, 28'h4333_551, 28'h5333_550, 28'hC333_651};
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, OFS_STAT_CFG, {16'h0, tbl[i][27:12]});
      for (int v = 0; v < 2; v++) begin
        cond_cmd <= 7'(v << tbl[i][11:8]);
        repeat (3) @(posedge pclk);
        chk(pin[tbl[i][7:4]], tbl[i][0] ? v == 0 : v == 1, "status pin");
      end
    end
  endtask : t_status
  task automatic t_brake;
    int n;
    apb(1'b1, OFS_STAT_CFG, 32'h3133);
    apb(1'b1, OFS_OUT_CFG, 32'h13);
    apb(1'b1, OFS_REL_WAIT, 32'h2);
    apb(1'b1, OFS_APP_WAIT, 32'h2);
    apb(1'b1, OFS_IRQ_MASK, 32'h6);
    cond_cmd <= 7'h01;
    repeat (4) @(posedge pclk);
    chk({pso, coil, mp, pin[4]}, 4'b1100, "release start");
    wait_for(mp, 1'b1, 60, n);
    chk(n + 4 >= 2 * TK && n + 4 <= 2 * TK + 8, 1'b1, "release time");
    chk(irq, 1'b1, "release irq");
    apb(1'b1, OFS_IRQ_STAT, 32'h2);
    cond_cmd <= 7'h00;
    repeat (4) @(posedge pclk);
    chk({pso, coil, mp}, 3'b100, "brake first");
    wait_for(pso, 1'b0, 60, n);
    chk(n + 4 >= 2 * TK && n + 4 <= 2 * TK + 8, 1'b1, "apply time");
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk(rd, 32'h4, "apply event");
    apb(1'b1, OFS_IRQ_STAT, 32'h4);
    apb(1'b1, OFS_OUT_CFG, 32'h23);
    apb(1'b1, OFS_REL_WAIT, 32'h0);
    cond_cmd <= 7'h01;
    wait_for(mp, 1'b1, 7, n);
    chk(pin[1], 1'b1, "inverted brake");
    cond_cmd <= 7'h00;
    wait_for(pso, 1'b0, 60, n);
    chk(pin[1], 1'b0, "inverted engage");
    apb(1'b1, OFS_OUT_CFG, 32'h33);
    apb(1'b1, OFS_REL_WAIT, 32'h5);
    cond_cmd <= 7'h01;
    wait_for(mp, 1'b1, 6, n);
    chk(pin[1], 1'b1, "general brake pin");
    cond_cmd <= 7'h00;
    wait_for(pso, 1'b0, 6, n);
  endtask : t_brake
  // ==========================================================
  // Clock, reset and main sequence
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    sw_cmd = 4'h0;
    ce = 1'b1;
    cond_cmd = 7'h00;
    err_total = 0;
    checked = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_inputs();
    t_hold();
    t_fault();
    t_status();
    t_brake();
    end_of_test();
  end
endmodule : servo_io_function_mapper_bench
